//--- logic/asm_defines.svh
`ifndef ASM_DEFINES_SVH
`define ASM_DEFINES_SVH
// ----------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------
`define ASM_ADDR_W 19
`define ASM_DATA_W 32
`define ASM_LANES 4
`define ASM_LANE_W 8
// ----------------------------------------------------------------
// Timing in nanoseconds at the slow grade, which also covers the fast grade
// ----------------------------------------------------------------
`define ASM_CLK_NS 25
`define ASM_CYCLE_NS 25
`define ASM_ACCESS_NS 25
`define ASM_WRITE_PULSE_NS 20
`define ASM_FLOAT_NS 10
`define ASM_CYCLE_CYC ((`ASM_CYCLE_NS + `ASM_CLK_NS - 1) / `ASM_CLK_NS)
`define ASM_ACCESS_CYC ((`ASM_ACCESS_NS + `ASM_CLK_NS - 1) / `ASM_CLK_NS)
`define ASM_PULSE_CYC ((`ASM_WRITE_PULSE_NS + `ASM_CLK_NS - 1) / `ASM_CLK_NS)
`define ASM_FLOAT_CYC ((`ASM_FLOAT_NS + `ASM_CLK_NS - 1) / `ASM_CLK_NS)
`define ASM_CNT_W 3
`define ASM_SIZE_BYTE 2'h0
`define ASM_SIZE_HALF 2'h1
`define ASM_SIZE_WORD 2'h2
`endif

//--- logic/asm_host.sv
// Contract
// - Half words pair lanes 0/1 and 2/3; words use all four selects.
// - Write strobe stays high through every read cycle.
// - Select low 20 ns before write end; write cycle 25 ns long.
// - Address stable at write start and 20 ns before write end.
// - Write pulse at least 15 ns.
// - Write data present 10 ns before write end, no hold needed.
// - Read address valid no later than select falling.
`timescale 1ns/1ps
`include "asm_defines.svh"
module asm_host (
  input wire logic clock,
  input wire logic nrst,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire asm_pkg::asm_size_t reqSize,
  input wire logic [`ASM_ADDR_W+1:0] reqAddr,
  input wire logic [`ASM_DATA_W-1:0] reqWdata,
  output logic rspValid,
  output logic [`ASM_DATA_W-1:0] rspRdata,
  output logic [`ASM_ADDR_W-1:0] memAddr,
  output logic lane0_select_n,
  output logic lane1_select_n,
  output logic lane2_select_n,
  output logic lane3_select_n,
  output logic memOutEnable_n,
  output logic memWrite_n,
  input wire logic [`ASM_DATA_W-1:0] memDataIn,
  output logic [`ASM_DATA_W-1:0] memDataOut,
  output logic memDataOe
);
  import asm_pkg::*;

  asm_state_t state;
  logic [`ASM_CNT_W-1:0] count;
  logic [3:0] laneSel;
  logic [3:0] selLatch;
  logic isWrite;

  asm_lane_decode uDecode (
    .size(reqSize),
    .laneIdx(reqAddr[1:0]),
    .laneSel(laneSel)
  );

  assign reqReady = (state == ASM_IDLE);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Every phase lasts at least one whole 25 ns clock, which meets the slow
  // grade and therefore the fast grade too; throughput is traded for one table.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ASM_IDLE;
      count <= '0;
    end else begin
      case (state)
        ASM_IDLE: begin
          if (reqValid) begin
            state <= reqWrite ? ASM_WR_SETUP : ASM_RD_SETUP;
            count <= '0;
          end
        end
        ASM_RD_SETUP: begin
          state <= ASM_RD_WAIT;
          count <= `ASM_CNT_W'(`ASM_ACCESS_CYC);
        end
        ASM_RD_WAIT: begin
          if (count <= `ASM_CNT_W'(1)) begin
            state <= ASM_RECOVER;
            count <= `ASM_CNT_W'(`ASM_FLOAT_CYC);
          end else begin
            count <= count - `ASM_CNT_W'(1);
          end
        end
        ASM_WR_SETUP: begin
          state <= ASM_WR_PULSE;
          count <= `ASM_CNT_W'(`ASM_PULSE_CYC);
        end
        ASM_WR_PULSE: begin
          if (count <= `ASM_CNT_W'(1)) begin
            state <= ASM_RECOVER;
            count <= `ASM_CNT_W'(`ASM_FLOAT_CYC);
          end else begin
            count <= count - `ASM_CNT_W'(1);
          end
        end
        ASM_RECOVER: begin
          if (count <= `ASM_CNT_W'(1)) begin
            state <= ASM_IDLE;
          end else begin
            count <= count - `ASM_CNT_W'(1);
          end
        end
        default: state <= ASM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memAddr <= '0;
      selLatch <= 4'h0;
      isWrite <= 1'b0;
      memDataOut <= '0;
    end else if (state == ASM_IDLE && reqValid) begin
      memAddr <= reqAddr[`ASM_ADDR_W+1:2];
      selLatch <= laneSel;
      isWrite <= reqWrite;
      memDataOut <= reqWdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin strobes
  // ----------------------------------------------------------------
  // The selects and the write strobe fall together one clock after the address
  // settles, and output enable stays high in a write, so the memory never drives.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lane0_select_n <= 1'b1;
      lane1_select_n <= 1'b1;
      lane2_select_n <= 1'b1;
      lane3_select_n <= 1'b1;
      memOutEnable_n <= 1'b1;
      memWrite_n <= 1'b1;
      memDataOe <= 1'b0;
    end else begin
      lane0_select_n <= !(selLatch[0] && (state == ASM_RD_SETUP || state == ASM_RD_WAIT ||
        state == ASM_WR_SETUP || state == ASM_WR_PULSE));
      lane1_select_n <= !(selLatch[1] && (state == ASM_RD_SETUP || state == ASM_RD_WAIT ||
        state == ASM_WR_SETUP || state == ASM_WR_PULSE));
      lane2_select_n <= !(selLatch[2] && (state == ASM_RD_SETUP || state == ASM_RD_WAIT ||
        state == ASM_WR_SETUP || state == ASM_WR_PULSE));
      lane3_select_n <= !(selLatch[3] && (state == ASM_RD_SETUP || state == ASM_RD_WAIT ||
        state == ASM_WR_SETUP || state == ASM_WR_PULSE));
      memOutEnable_n <= !(state == ASM_RD_SETUP || state == ASM_RD_WAIT);
      memWrite_n <= !(state == ASM_WR_SETUP || state == ASM_WR_PULSE);
      memDataOe <= (state == ASM_WR_SETUP || state == ASM_WR_PULSE);
    end
  end

  // ----------------------------------------------------------------
  // Read return
  // ----------------------------------------------------------------
  // Only the selected lanes are taken; the others read back as zero.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rspValid <= 1'b0;
      rspRdata <= '0;
    end else begin
      rspValid <= 1'b0;
      if (state == ASM_RD_WAIT && count <= `ASM_CNT_W'(1)) begin
        rspValid <= 1'b1;
        for (int i = 0; i < `ASM_LANES; i++) begin
          rspRdata[i*`ASM_LANE_W +: `ASM_LANE_W] <= selLatch[i] ?
            memDataIn[i*`ASM_LANE_W +: `ASM_LANE_W] : '0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rd_we_high;
    @(posedge clock) disable iff (!nrst) !memOutEnable_n |-> memWrite_n;
  endproperty
  a_rd_we_high: assert property (p_rd_we_high) else $error("write strobe low in read");

  property p_no_drive_in_read;
    @(posedge clock) disable iff (!nrst) !memOutEnable_n |-> !memDataOe;
  endproperty
  a_no_drive_in_read: assert property (p_no_drive_in_read)
    else $error("host drives during read");

  // A select that fell before the write strobe would let the memory drive for a moment.
  property p_sel_before_we;
    @(posedge clock) disable iff (!nrst) $fell(memWrite_n) |-> memOutEnable_n
      && !(lane0_select_n && lane1_select_n && lane2_select_n && lane3_select_n)
      && $past(lane0_select_n && lane1_select_n && lane2_select_n && lane3_select_n);
  endproperty
  a_sel_before_we: assert property (p_sel_before_we)
    else $error("select and write strobe did not fall together");

  sequence s_write_low;
    !memWrite_n [*2];
  endsequence
  property p_pulse_len;
    @(posedge clock) disable iff (!nrst) $fell(memWrite_n) |-> s_write_low;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("write pulse too short");

  property p_addr_stable_wr;
    @(posedge clock) disable iff (!nrst) !memWrite_n |-> $stable(memAddr);
  endproperty
  a_addr_stable_wr: assert property (p_addr_stable_wr)
    else $error("address moved in write");

  property p_data_with_we;
    @(posedge clock) disable iff (!nrst) !memWrite_n |-> memDataOe && $stable(memDataOut);
  endproperty
  a_data_with_we: assert property (p_data_with_we) else $error("write data missing");

  property p_read_len;
    @(posedge clock) disable iff (!nrst) $fell(memOutEnable_n) |-> !memOutEnable_n [*2];
  endproperty
  a_read_len: assert property (p_read_len) else $error("read cycle too short");

  property p_idle_float;
    @(posedge clock) disable iff (!nrst) memOutEnable_n && memWrite_n |-> !memDataOe;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("bus driven while idle");

  property p_rsp_after_read;
    @(posedge clock) disable iff (!nrst) rspValid |-> $past(!memOutEnable_n);
  endproperty
  a_rsp_after_read: assert property (p_rsp_after_read)
    else $error("response without read");
endmodule : asm_host

//--- logic/asm_lane_decode.sv
`timescale 1ns/1ps
`include "asm_defines.svh"
module asm_lane_decode (
  input wire logic [1:0] size,
  input wire logic [1:0] laneIdx,
  output logic [3:0] laneSel
);
  // ----------------------------------------------------------------
  // Lane selection
  // ----------------------------------------------------------------
  always_comb begin
    case (size)
      `ASM_SIZE_WORD: laneSel = 4'hf;
      `ASM_SIZE_HALF: laneSel = laneIdx[1] ? 4'hc : 4'h3;
      default: laneSel = 4'h1 << laneIdx;
    endcase
  end
endmodule : asm_lane_decode

//--- logic/asm_pkg.sv
package asm_pkg;
  typedef enum logic [2:0] {
    ASM_IDLE, ASM_RD_SETUP, ASM_RD_WAIT, ASM_WR_SETUP, ASM_WR_PULSE, ASM_RECOVER
  } asm_state_t;
  typedef logic [1:0] asm_size_t;
endpackage : asm_pkg

//--- sim/asm_host_tb.sv
`timescale 1ns/1ps
`include "asm_defines.svh"
module asm_host_tb;
  import asm_pkg::*;
  logic clock = 0;
  logic nrst = 0;
  logic reqValid = 0;
  logic reqWrite = 0;
  asm_size_t reqSize = 2'h0;
  logic [20:0] reqAddr = 21'h0;
  logic [31:0] reqWdata = 32'h0;
  logic [31:0] rspRdata, memDataOut, devData, busData;
  logic [18:0] memAddr;
  logic reqReady, rspValid, memDataOe, memOutEnable_n, memWrite_n;
  logic lane0_select_n, lane1_select_n, lane2_select_n, lane3_select_n;
  logic [31:0] refMem [int];
  int failCount = 0;
  int checksDone = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  assign busData = memDataOe ? memDataOut : devData;
  asm_host uut (.clock(clock), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqSize(reqSize), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .rspValid(rspValid), .rspRdata(rspRdata), .memAddr(memAddr),
    .lane0_select_n(lane0_select_n), .lane1_select_n(lane1_select_n),
    .lane2_select_n(lane2_select_n), .lane3_select_n(lane3_select_n),
    .memOutEnable_n(memOutEnable_n), .memWrite_n(memWrite_n), .memDataIn(busData),
    .memDataOut(memDataOut), .memDataOe(memDataOe));
  asm_sram_model dev (.memAddr(memAddr), .lane0_select_n(lane0_select_n),
    .lane1_select_n(lane1_select_n), .lane2_select_n(lane2_select_n),
    .lane3_select_n(lane3_select_n), .memOutEnable_n(memOutEnable_n),
    .memWrite_n(memWrite_n), .busData(busData), .devData(devData));
  task automatic tallyAndFinish();
    $display("Checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tallyAndFinish
  // A hang counts as a mismatch and ends the run.
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 20000) begin
      failCount++;
      tallyAndFinish();
    end
  end
  task automatic cmp32(logic [31:0] got, logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp32
  function automatic logic [3:0] laneMask(logic [1:0] sz, logic [1:0] a);
    return sz == 2'h0 ? 4'h1 << a : sz == 2'h1 ? (a[1] ? 4'hc : 4'h3) : 4'hf;
  endfunction : laneMask
  task automatic access(logic w, logic [1:0] sz, logic [20:0] a, logic [31:0] d);
    logic [3:0] lm, seen;
    logic [31:0] m, old;
    logic weLow, clash, done;
    int n;
    lm = laneMask(sz, a[1:0]);
    m = {{8{lm[3]}}, {8{lm[2]}}, {8{lm[1]}}, {8{lm[0]}}};
    old = refMem.exists(a[20:2]) ? refMem[a[20:2]] : {13'h0, a[20:2]};
    seen = 4'h0;
    weLow = 0;
    clash = 0;
    done = 0;
    @(negedge clock);
    reqValid = 1;
    reqWrite = w;
    reqSize = sz;
    reqAddr = a;
    reqWdata = d;
    n = 0;
    while (reqReady !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    reqValid = 0;
    for (n = 0; n < 10 && !done; n++) begin
      seen = seen | ~{lane3_select_n, lane2_select_n, lane1_select_n, lane0_select_n};
      weLow = weLow | !memWrite_n;
      clash = clash | (memDataOe & !memOutEnable_n);
      done = w ? reqReady : rspValid;
      if (!done) @(negedge clock);
    end
    cmp32({31'h0, done}, 32'h1);
    cmp32({28'h0, seen}, {28'h0, lm});
    cmp32({31'h0, clash}, 32'h0);
    if (w) begin
      refMem[a[20:2]] = (old & ~m) | (d & m);
      cmp32({31'h0, weLow}, 32'h1);
    end else begin
      cmp32({31'h0, weLow}, 32'h0);
      cmp32(rspRdata, old & m);
    end
  endtask : access
  initial begin
    int s;
    s = $urandom(89);
    repeat (5) @(posedge clock);
    cmp32({28'h0, lane3_select_n, lane2_select_n, lane1_select_n, lane0_select_n},
      32'hf);
    cmp32({30'h0, memOutEnable_n, memWrite_n}, 32'h3);
    @(negedge clock);
    nrst = 1;
    for (int z = 0; z < 3; z++) begin
      for (int l = 0; l < 4; l++) begin
        access(1'b1, 2'(z), {19'h5, 2'(l)}, $urandom);
        access(1'b0, 2'(z), {19'h5, 2'(l)}, 32'h0);
      end
    end
    $display("Lane and size sweep done");
    repeat (60) begin
      access(1'($urandom), 2'($urandom % 3), {16'h0, 3'($urandom), 2'($urandom)},
        $urandom);
    end
    $display("Random traffic done");
    tallyAndFinish();
  end
endmodule : asm_host_tb

//--- sim/asm_sram_model.sv
`timescale 1ns/1ps
module asm_sram_model (
  input wire logic [18:0] memAddr,
  input wire logic lane0_select_n,
  input wire logic lane1_select_n,
  input wire logic lane2_select_n,
  input wire logic lane3_select_n,
  input wire logic memOutEnable_n,
  input wire logic memWrite_n,
  input wire logic [31:0] busData,
  output logic [31:0] devData
);
  // ------------------------------------------------
  // Storage and pin decode
  // ------------------------------------------------
  logic [31:0] mem [int];
  logic [31:0] busD;
  logic [31:0] junk = 32'h5a3c96e1;
  logic [31:0] word;
  logic [18:0] aD;
  logic [18:0] addrD;
  logic [3:0] sel;
  logic [3:0] wrOn;
  logic [3:0] drv;
  logic [3:0] drvD;
  logic [3:0] wrPrev = 4'h0;
  function automatic logic [31:0] rdWord(logic [18:0] a);
    return mem.exists(a) ? mem[a] : {13'h0, a};
  endfunction : rdWord
  assign sel = ~{lane3_select_n, lane2_select_n, lane1_select_n, lane0_select_n};
  assign wrOn = sel & {4{~memWrite_n}};
  // A select that meets a low write strobe never drives, so the bus stays free.
  assign drv = sel & {4{~memOutEnable_n & memWrite_n}};
  assign #22 drvD = drv;
  assign #22 addrD = memAddr;
  // Released lanes toggle so that a stale value never reads as good data.
  always #5 junk = ~junk;
  always @(busData) busD <= #1 busData;
  always @(memAddr) aD <= #1 memAddr;
  // Storage is touched only when a lane ends its write, so unknown strobes before
  // reset never create an entry at an unknown address.
  always @(wrOn) begin
    if ((wrPrev & ~wrOn) != 4'h0) begin
      word = rdWord(aD);
      for (int i = 0; i < 4; i++) begin
        if (wrPrev[i] && !wrOn[i]) word[i*8+:8] = busD[i*8+:8];
      end
      mem[aD] = word;
    end
    wrPrev = wrOn;
  end
  always @(memAddr or drv or drvD or addrD or junk or wrOn) begin
    for (int i = 0; i < 4; i++) begin
      devData[i*8+:8] = !drv[i] ? junk[i*8+:8] : (drvD[i] && addrD == memAddr) ?
        rdWord(memAddr) >> (i*8) : ~(rdWord(memAddr) >> (i*8));
    end
  end
endmodule : asm_sram_model
